// file: rtl/dcsq_top.sv
// dcsq_top: descriptor sequencer with condition-select registers and AHB-Lite slave
`timescale 1ns/100ps
// Functional notes
// - interrupt condition: masked state equals masked value
// - reserved select bits 31-24, 15-8 read zero
// - branch select decides branch at completion
// - wait select decides suspension at completion
// - interrupt condition drives hardwired interrupt
// - one command pointer per channel
// - activation fetches from channel pointer
// - fetch and execute until STOP
// - pointer plus 16, jump, or unchanged
// - write status back, signal descriptor done
// - shared event channel reports list index
// - wait holds until release arrives
// - resume refetches; cleared after each fetch
// - STOP idles without pointer increment
module dcsq_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    input wire logic fetch_ack,
    input wire logic [3:0] fetch_cmd,
    input wire logic [1:0] fetch_int,
    input wire logic [1:0] fetch_br,
    input wire logic [1:0] fetch_wait,
    input wire logic [31:0] fetch_jump_target,
    output logic xfer_req,
    input wire logic xfer_done,
    output logic wb_req,
    output logic [31:0] wb_addr,
    output logic [31:0] wb_data,
    input wire logic wb_ack,
    output logic descriptor_done,
    input wire logic [7:0] hw_state_set,
    input wire logic [7:0] hw_state_clr,
    input wire logic [dcsq_pkg::NCH-1:0] dev_event,
    output logic irq
);
    import dcsq_pkg::*;

    localparam int SYW = 16 + NCH; // synchroniser width

    // condition test against a select register
    function automatic logic cond_hit(input logic [31:0] sel, input logic [7:0] s);
        cond_hit = (s & sel[MASK_HI:MASK_LO]) == (sel[VAL_HI:VAL_LO] & sel[MASK_HI:MASK_LO]);
    endfunction : cond_hit

    // per-command field decides how the condition is used
    function automatic logic cond_act(input logic [1:0] f, input logic c);
        unique case (f)
            COND_NEVER: cond_act = 1'b0;
            COND_TRUE: cond_act = c;
            COND_FALSE: cond_act = ~c;
            COND_ALWAYS: cond_act = 1'b1;
        endcase
    endfunction : cond_act

    logic [SYW-1:0] sync1_q; // first stage, read only by sync2_q
    logic [SYW-1:0] sync2_q; // safe copies of device pins
    logic [7:0] set_s;
    logic [7:0] clr_s;
    logic [NCH-1:0] evt_s;
    logic acc; // accepted address phase
    logic wr_pend_q; // write data phase pending
    logic [7:0] wr_addr_q;
    logic [31:0] rd_d;
    logic [31:0] hrdata_q;
    logic run_q;
    logic run_seen_q; // channel already started since run went high
    logic wake_q; // resume_request
    logic [CHW-1:0] ch_sel_q;
    logic [7:0] state_q; // channel_state_bits
    logic [31:0] isel_q; // interrupt_condition_select
    logic [31:0] bsel_q; // branch_condition_select
    logic [31:0] wsel_q; // wait_condition_select
    logic [31:0] ptr_q [NCH]; // next_descriptor_pointer per channel
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [IRQ_W-1:0] irq_set;
    logic [NCH-1:0] evt_q;
    logic evt_any;
    logic [CHW-1:0] evt_idx;
    dcsq_state_t st_q;
    logic act_q;
    logic [CHW-1:0] ch_q;
    logic [1:0] fi_q;
    logic [1:0] fb_q;
    logic [1:0] fw_q;
    logic [31:0] jump_q;
    logic [31:0] fetch_addr_q;
    logic [7:0] snap_q;
    logic int_q;
    logic br_q;
    logic wt_q;
    logic done_q;
    logic [31:0] wb_addr_q;
    logic [31:0] wb_data_q;
    logic w_ctrl;
    logic w_ptr;
    logic cmpl; // command completes this cycle
    logic int_now;
    logic br_now;
    logic wt_now;
    logic adv; // pointer update strobe
    logic stop_ev;
    logic evt_pop;
    logic [31:0] nxt_ptr;

    assign {evt_s, clr_s, set_s} = sync2_q;

    // two-stage synchroniser for all device-side pins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce) begin
            sync1_q <= {dev_event, hw_state_clr, hw_state_set};
            sync2_q <= sync1_q;
        end
    end

    // ---- AHB-Lite slave: zero wait state, always OKAY ----
    assign acc = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign w_ctrl = wr_pend_q && (wr_addr_q == A_CTRL);
    assign w_ptr = wr_pend_q && (wr_addr_q == A_PTR);

    // read mux; reserved and unmapped bits read zero
    always_comb begin
        rd_d = '0;
        unique case (haddr[7:0])
            A_CTRL: rd_d = {16'h0000, state_q, 5'h00, ch_sel_q, wake_q, run_q};
            A_STAT: rd_d = {16'h0000, state_q, 5'h00, st_q == S_WAITC, act_q, run_q};
            A_PTR: rd_d = ptr_q[ch_sel_q];
            A_ISEL: rd_d = isel_q;
            A_BSEL: rd_d = bsel_q;
            A_WSEL: rd_d = wsel_q;
            A_IRQS: rd_d = {29'h0, irq_stat_q};
            A_IRQE: rd_d = {29'h0, irq_en_q};
            A_EVT: rd_d = {evt_any, 30'h0, evt_idx};
            default: rd_d = '0;
        endcase
    end

    // address phase capture; read data is ready in the data phase
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q <= '0;
        end else if (ce) begin
            wr_pend_q <= acc & hwrite;
            wr_addr_q <= haddr[7:0];
            hrdata_q <= (acc & ~hwrite) ? rd_d : '0;
        end
    end

    // select registers hold only mask and value; reserved bits stay zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            isel_q <= '0;
            bsel_q <= '0;
            wsel_q <= '0;
        end else if (ce && wr_pend_q) begin
            if (wr_addr_q == A_ISEL) begin
                isel_q <= {8'h00, hwdata[MASK_HI:MASK_LO], 8'h00, hwdata[VAL_HI:VAL_LO]};
            end
            if (wr_addr_q == A_BSEL) begin
                bsel_q <= {8'h00, hwdata[MASK_HI:MASK_LO], 8'h00, hwdata[VAL_HI:VAL_LO]};
            end
            if (wr_addr_q == A_WSEL) begin
                wsel_q <= {8'h00, hwdata[MASK_HI:MASK_LO], 8'h00, hwdata[VAL_HI:VAL_LO]};
            end
        end
    end

    // control: run, channel select, resume request
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 1'b0;
            ch_sel_q <= '0;
            wake_q <= 1'b0;
        end else if (ce) begin
            if (w_ctrl) begin
                run_q <= hwdata[CTRL_RUN];
                ch_sel_q <= hwdata[CTRL_CH +: CHW];
            end
            // software set beats the post-fetch clear
            if (w_ctrl && hwdata[CTRL_WAKE]) begin
                wake_q <= 1'b1;
            end else if (st_q == S_FETCH && fetch_ack) begin
                wake_q <= 1'b0;
            end
        end
    end

    // state bits: software write, then device clear, device set wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= '0;
        end else if (ce) begin
            state_q <= ((w_ctrl ? hwdata[ST_HI:ST_LO] : state_q) & ~clr_s) | set_s;
        end
    end

    // pointer array; software writes only while stopped and inactive
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++) begin
                ptr_q[i] <= '0;
            end
        end else if (ce) begin
            if (adv) begin
                ptr_q[ch_q] <= nxt_ptr;
            end else if (w_ptr && !run_q && !act_q) begin
                ptr_q[ch_sel_q] <= hwdata & PTR_ALIGN;
            end
        end
    end

    // ---- sequencer ----
    // conditions from live state; latched together at completion
    assign int_now = cond_act(fi_q, cond_hit(isel_q, state_q));
    assign br_now = cond_act(fb_q, cond_hit(bsel_q, state_q));
    assign wt_now = cond_act(fw_q, cond_hit(wsel_q, state_q));
    assign cmpl = (st_q == S_XFER && xfer_done)
        || (st_q == S_FETCH && fetch_ack && fetch_cmd == CMD_NOP);
    assign adv = (st_q == S_WRBACK) && wb_ack && run_q;
    assign stop_ev = (st_q == S_FETCH) && fetch_ack && (fetch_cmd == CMD_STOP) && run_q;
    assign nxt_ptr = br_q ? (jump_q & PTR_ALIGN) : fetch_addr_q + PTR_STEP;

    assign fetch_req = (st_q == S_FETCH);
    assign xfer_req = (st_q == S_XFER);
    assign wb_req = (st_q == S_WRBACK);
    assign fetch_addr = fetch_addr_q;
    assign wb_addr = wb_addr_q;
    assign wb_data = wb_data_q;
    assign descriptor_done = done_q;

    // command fetch, execute, write back, wait loop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= S_IDLE;
            act_q <= 1'b0;
            run_seen_q <= 1'b0;
            ch_q <= '0;
            fi_q <= COND_NEVER;
            fb_q <= COND_NEVER;
            fw_q <= COND_NEVER;
            jump_q <= '0;
            fetch_addr_q <= '0;
            snap_q <= '0;
            int_q <= 1'b0;
            br_q <= 1'b0;
            wt_q <= 1'b0;
            done_q <= 1'b0;
            wb_addr_q <= '0;
            wb_data_q <= '0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (!run_q) begin
                // clearing run abandons the current command
                st_q <= S_IDLE;
                act_q <= 1'b0;
                run_seen_q <= 1'b0;
            end else begin
                unique case (st_q)
                    S_IDLE: begin
                        // first start after run, or a resume request
                        if (!run_seen_q || wake_q) begin
                            st_q <= S_FETCH;
                            act_q <= 1'b1;
                            run_seen_q <= 1'b1;
                            ch_q <= ch_sel_q;
                            fetch_addr_q <= ptr_q[ch_sel_q];
                        end
                    end
                    S_FETCH: begin
                        if (fetch_ack) begin
                            fi_q <= fetch_int;
                            fb_q <= fetch_br;
                            fw_q <= fetch_wait;
                            jump_q <= fetch_jump_target;
                            if (fetch_cmd == CMD_STOP) begin
                                st_q <= S_IDLE;
                                act_q <= 1'b0;
                            end else if (fetch_cmd != CMD_NOP) begin
                                st_q <= S_XFER;
                            end
                        end
                    end
                    S_XFER: begin
                        // transfer engine owns the cycle count
                    end
                    S_WRBACK: begin
                        if (wb_ack) begin
                            done_q <= 1'b1;
                            fetch_addr_q <= nxt_ptr;
                            st_q <= wt_q ? S_WAITC : S_FETCH;
                        end
                    end
                    S_WAITC: begin
                        // released when the wait condition no longer holds for the state bits
                        if (!cond_act(fw_q, cond_hit(wsel_q, state_q))) begin
                            st_q <= S_FETCH;
                        end
                    end
                endcase
                if (cmpl) begin
                    // NOP completes straight from fetch with its own fields
                    snap_q <= state_q;
                    if (st_q == S_FETCH) begin
                        int_q <= cond_act(fetch_int, cond_hit(isel_q, state_q));
                        br_q <= cond_act(fetch_br, cond_hit(bsel_q, state_q));
                        wt_q <= cond_act(fetch_wait, cond_hit(wsel_q, state_q));
                    end else begin
                        int_q <= int_now;
                        br_q <= br_now;
                        wt_q <= wt_now;
                    end
                    wb_addr_q <= fetch_addr_q + STATUS_OFS;
                    wb_data_q <= {5'h00, 1'b1, 1'b0,
                        (st_q == S_FETCH) ? cond_act(fetch_br, cond_hit(bsel_q, state_q))
                        : br_now, state_q, 16'h0000};
                    st_q <= S_WRBACK;
                end
            end
        end
    end

    // ---- shared event channel ----
    // lowest pending channel is reported first
    always_comb begin
        evt_idx = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (evt_q[i]) begin
                evt_idx = i[CHW-1:0];
            end
        end
    end
    assign evt_any = |evt_q;
    assign evt_pop = acc && !hwrite && (haddr[7:0] == A_EVT);

    // a read pops the reported entry; a new event wins over the pop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            evt_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < NCH; i++) begin
                if (evt_s[i]) begin
                    evt_q[i] <= 1'b1;
                end else if (evt_pop && evt_any && evt_idx == i[CHW-1:0]) begin
                    evt_q[i] <= 1'b0;
                end
            end
        end
    end

    // ---- interrupts: sticky status, write-one clear, enable ----
    assign irq_set[IRQ_DONE] = adv && int_q;
    assign irq_set[IRQ_STOP] = stop_ev;
    assign irq_set[IRQ_EVT] = evt_any;
    assign irq = |(irq_stat_q & irq_en_q);

    // set beats clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
        end else if (ce) begin
            irq_stat_q <= (irq_stat_q
                & ~((wr_pend_q && wr_addr_q == A_IRQC) ? hwdata[IRQ_W-1:0] : '0)) | irq_set;
            if (wr_pend_q && wr_addr_q == A_IRQE) begin
                irq_en_q <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // ---- assertions ----
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn || !ce);

    property p_int_irq;
        adv && int_q |=> irq_stat_q[IRQ_DONE];
    endproperty
    a_int_irq: assert property (p_int_irq) else $error("interrupt condition lost");

    property p_int_cond;
        (st_q == S_XFER) && xfer_done && run_q && fi_q == COND_TRUE
            |=> int_q == ((snap_q & isel_q[MASK_HI:MASK_LO])
                == (isel_q[VAL_HI:VAL_LO] & isel_q[MASK_HI:MASK_LO]));
    endproperty
    a_int_cond: assert property (p_int_cond) else $error("bad interrupt condition");

    property p_step;
        adv && !br_q |=> ptr_q[$past(ch_q)] == $past(fetch_addr_q) + PTR_STEP;
    endproperty
    a_step: assert property (p_step) else $error("pointer not advanced by 16");

    property p_jump;
        adv && br_q |=> fetch_addr_q == ($past(jump_q) & PTR_ALIGN);
    endproperty
    a_jump: assert property (p_jump) else $error("branch not taken");

    property p_stop;
        stop_ev |=> st_q == S_IDLE && !act_q && $stable(ptr_q[ch_q]);
    endproperty
    a_stop: assert property (p_stop) else $error("stop handling wrong");

    property p_wake_clr;
        (st_q == S_FETCH) && fetch_ack && !w_ctrl |=> !wake_q;
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("resume not cleared");

    property p_start;
        (st_q == S_IDLE) && run_q && wake_q
            |=> st_q == S_FETCH ##0 fetch_req ##0 fetch_addr == $past(ptr_q[ch_sel_q]);
    endproperty
    a_start: assert property (p_start) else $error("fetch not from pointer");

    property p_wait;
        adv && wt_q |=> st_q == S_WAITC;
    endproperty
    a_wait: assert property (p_wait) else $error("wait not entered");

    property p_done;
        adv |=> descriptor_done ##1 !descriptor_done;
    endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
endmodule : dcsq_top

// file: common/dcsq_pkg.sv
// dcsq_pkg: shared constants and types of the condition sequencer
package dcsq_pkg;
    // register byte offsets (low address byte)
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_PTR = 8'h0c;
    localparam logic [7:0] A_ISEL = 8'h10;
    localparam logic [7:0] A_BSEL = 8'h14;
    localparam logic [7:0] A_WSEL = 8'h18;
    localparam logic [7:0] A_IRQS = 8'h20;
    localparam logic [7:0] A_IRQC = 8'h24;
    localparam logic [7:0] A_IRQE = 8'h28;
    localparam logic [7:0] A_EVT = 8'h2c;
    // condition-select field layout
    localparam int MASK_HI = 23;
    localparam int MASK_LO = 16;
    localparam int VAL_HI = 7;
    localparam int VAL_LO = 0;
    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_WAKE = 1;
    localparam int CTRL_CH = 2;
    localparam int ST_HI = 15;
    localparam int ST_LO = 8;
    // status and event register fields
    localparam int STAT_ACT = 1;
    localparam int STAT_WAIT = 2;
    localparam int EVT_VALID = 31;
    // channels
    localparam int NCH = 2;
    localparam int CHW = 1;
    // pointer handling
    localparam logic [31:0] PTR_STEP = 32'h0000_0010;
    localparam logic [31:0] PTR_ALIGN = 32'hffff_fff0;
    localparam logic [31:0] STATUS_OFS = 32'h0000_000c;
    // command codes
    localparam logic [3:0] CMD_NOP = 4'h6;
    localparam logic [3:0] CMD_STOP = 4'h7;
    // per-command condition field codes
    localparam logic [1:0] COND_NEVER = 2'h0;
    localparam logic [1:0] COND_TRUE = 2'h1;
    localparam logic [1:0] COND_FALSE = 2'h2;
    localparam logic [1:0] COND_ALWAYS = 2'h3;
    // interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_EVT = 2;
    // sequencer states
    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_XFER, S_WRBACK, S_WAITC} dcsq_state_t;
endpackage : dcsq_pkg

// file: verification/dcsq_mem_model.sv
// dcsq_mem_model: descriptor memory and far-side handshakes of the sequencer
`timescale 1ns/100ps
module dcsq_mem_model (
    input wire logic mclk,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_ack,
    output logic [3:0] fetch_cmd,
    output logic [1:0] fetch_int,
    output logic [1:0] fetch_br,
    output logic [1:0] fetch_wait,
    output logic [31:0] fetch_jump_target,
    input wire logic xfer_req,
    output logic xfer_done,
    input wire logic wb_req,
    input wire logic [31:0] wb_addr,
    input wire logic [31:0] wb_data,
    output logic wb_ack
);
    logic [41:0] mem [256]; // {cmd, int, branch, wait, jump} per 16-byte slot
    logic [41:0] fld = 42'h0; // fields shown to the fetch port
    logic [31:0] f_q[$], wa_q[$], wd_q[$]; // observed traffic
    logic [1:0] pace = 2'h0; // varies answer delay between prompt and slow
    initial begin
        fetch_ack = 1'b0;
        xfer_done = 1'b0;
        wb_ack = 1'b0;
    end
    assign {fetch_cmd, fetch_int, fetch_br, fetch_wait, fetch_jump_target} = fld;
    // answer each request once; fields change every cycle outside the answer
    always @(posedge mclk) begin
        pace <= pace + 2'h1;
        fetch_ack <= 1'b0;
        xfer_done <= 1'b0;
        wb_ack <= 1'b0;
        fld <= ~fld;
        if (fetch_req === 1'b1 && !fetch_ack && pace[0]) begin
            fetch_ack <= 1'b1;
            fld <= mem[fetch_addr[11:4]];
            f_q.push_back(fetch_addr);
        end
        if (xfer_req === 1'b1 && !xfer_done && pace == 2'h3) begin
            xfer_done <= 1'b1;
        end
        if (wb_req === 1'b1 && !wb_ack && pace[1]) begin
            wb_ack <= 1'b1;
            wa_q.push_back(wb_addr);
            wd_q.push_back(wb_data);
        end
    end
endmodule : dcsq_mem_model

// file: verification/tb_descriptor_dma_condition_sequencer.sv
// tb_descriptor_dma_condition_sequencer: register, sequencing and interrupt tests
`timescale 1ns/100ps
module tb_descriptor_dma_condition_sequencer;
    import dcsq_pkg::*;
    logic mclk = 1'b0; // 250 MHz
    logic resetn = 1'b0; // active low
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, irq;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2; // word transfers only
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, d;
    logic fetch_req, fetch_ack, xfer_req, xfer_done, wb_req, wb_ack, descriptor_done;
    logic [3:0] fetch_cmd;
    logic [1:0] fetch_int, fetch_br, fetch_wait;
    logic [31:0] fetch_addr, fetch_jump_target, wb_addr, wb_data;
    logic [7:0] hw_state_set = 8'h00, hw_state_clr = 8'h00, st = 8'h00;
    logic [NCH-1:0] dev_event = 2'h0;
    int n_fail = 0, checks_done = 0, cycles = 0, n_done = 0, seed = 25141;
    assign hready = hreadyout; // single slave
    always #2 mclk = ~mclk;
    dcsq_top dut_u (.mclk(mclk), .resetn(resetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_cmd(fetch_cmd),
        .fetch_int(fetch_int), .fetch_br(fetch_br), .fetch_wait(fetch_wait),
        .fetch_jump_target(fetch_jump_target), .xfer_req(xfer_req), .xfer_done(xfer_done),
        .wb_req(wb_req), .wb_addr(wb_addr), .wb_data(wb_data), .wb_ack(wb_ack),
        .descriptor_done(descriptor_done), .hw_state_set(hw_state_set),
        .hw_state_clr(hw_state_clr), .dev_event(dev_event), .irq(irq));
    dcsq_mem_model mem_u (.mclk(mclk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_ack(fetch_ack), .fetch_cmd(fetch_cmd), .fetch_int(fetch_int),
        .fetch_br(fetch_br), .fetch_wait(fetch_wait), .fetch_jump_target(fetch_jump_target),
        .xfer_req(xfer_req), .xfer_done(xfer_done), .wb_req(wb_req), .wb_addr(wb_addr),
        .wb_data(wb_data), .wb_ack(wb_ack));
    // compare one value, count and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    // compare traffic seen by the far side with the expected list
    task automatic cmp_q(input logic [31:0] seen[$], input logic [31:0] want[$]);
        chk(32'(seen.size()), 32'(want.size()));
        foreach (want[i]) chk(seen[i], want[i]);
    endtask : cmp_q
    // one single AHB-Lite transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata; // taken at the closing edge, before that edge updates it
    endtask : ahb
    // control write keeps the bench copy of the state bits
    task automatic ctrl(input logic [7:0] low);
        ahb(1'b1, A_CTRL, {16'h0, st, low});
    endtask : ctrl
    // bounded poll of one status bit
    task automatic poll(input int b, input logic v);
        for (int i = 0; i < 200; i++) begin
            ahb(1'b0, A_STAT, 32'h0);
            if (r[b] === v) break;
        end
        chk({31'h0, r[b]}, {31'h0, v});
    endtask : poll
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // cut a hang short; count completion pulses
    always @(posedge mclk) begin
        cycles++;
        if (descriptor_done === 1'b1) n_done++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        // random select words; reserved fields read zero
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            ahb(1'b1, A_ISEL + 8'(4 * i), d);
            ahb(1'b0, A_ISEL + 8'(4 * i), 32'h0);
            chk(r, d & 32'h00ff_00ff);
        end
        ahb(1'b0, 8'h3c, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test registers done");
        // NOP branching to 0x200, transfer that waits, then STOP
        mem_u.mem[8'h10] = {CMD_NOP, COND_TRUE, COND_TRUE, COND_NEVER, 32'h200};
        mem_u.mem[8'h20] = {4'h0, COND_TRUE, COND_FALSE, COND_TRUE, 32'h0};
        mem_u.mem[8'h21] = {CMD_STOP, COND_NEVER, COND_NEVER, COND_NEVER, 32'h0};
        ahb(1'b1, A_ISEL, 32'h00f0_0050); // matches 0x5a
        ahb(1'b1, A_BSEL, 32'h000f_000a); // matches 0x5a
        ahb(1'b1, A_WSEL, 32'h0001_0000); // matches while bit 0 is clear
        ahb(1'b1, A_IRQE, 32'h3);
        st = 8'h5a;
        ctrl(8'h00);
        ahb(1'b1, A_PTR, 32'h100);
        ctrl(8'h01);
        poll(STAT_WAIT, 1'b1);
        chk({31'h0, irq}, 32'h1);
        hw_state_set <= 8'h01; // device releases the wait
        repeat (4) @(posedge mclk);
        hw_state_set <= 8'h00;
        poll(STAT_ACT, 1'b0);
        ahb(1'b0, A_PTR, 32'h0);
        chk(r, 32'h210);
        cmp_q(mem_u.f_q, '{32'h100, 32'h200, 32'h210});
        cmp_q(mem_u.wa_q, '{32'h10c, 32'h20c});
        cmp_q(mem_u.wd_q, '{32'h055a_0000, 32'h045a_0000});
        chk(32'(n_done), 32'h2);
        // device pin clears state bit 0 again; channel idle, run still set
        hw_state_clr <= 8'h01;
        repeat (4) @(posedge mclk);
        hw_state_clr <= 8'h00;
        ahb(1'b0, A_STAT, 32'h0);
        chk(r, 32'h0000_5a01);
        ahb(1'b0, A_IRQS, 32'h0);
        chk(r, 32'h3);
        ahb(1'b1, A_IRQC, 32'h3);
        ahb(1'b0, A_IRQS, 32'h0);
        chk(r | {31'h0, irq}, 32'h0);
        $display("test sequence done");
        // append by turning the STOP into a NOP, then wake the channel
        mem_u.mem[8'h22] = {CMD_STOP, COND_NEVER, COND_NEVER, COND_NEVER, 32'h0};
        mem_u.mem[8'h21] = {CMD_NOP, COND_ALWAYS, COND_NEVER, COND_NEVER, 32'h0};
        ahb(1'b1, A_IRQE, 32'h0);
        st = 8'h5b;
        ctrl(8'h03);
        for (int i = 0; i < 200 && mem_u.f_q.size() < 5; i++) @(posedge mclk);
        poll(STAT_ACT, 1'b0);
        ahb(1'b0, A_CTRL, 32'h0);
        chk(r & 32'h2, 32'h0);
        ahb(1'b0, A_PTR, 32'h0);
        chk(r, 32'h220);
        cmp_q(mem_u.f_q, '{32'h100, 32'h200, 32'h210, 32'h210, 32'h220});
        cmp_q(mem_u.wd_q, '{32'h055a_0000, 32'h045a_0000, 32'h045b_0000});
        ahb(1'b0, A_IRQS, 32'h0);
        chk(r | {31'h0, irq}, 32'h3);
        ctrl(8'h04);
        ahb(1'b1, A_PTR, 32'h300);
        ahb(1'b0, A_PTR, 32'h0);
        chk(r, 32'h300);
        ctrl(8'h00);
        ahb(1'b0, A_PTR, 32'h0);
        chk(r, 32'h220);
        $display("test append done");
        // event on channel 1 is reported with its index, then popped
        dev_event <= 2'h2;
        repeat (4) @(posedge mclk);
        dev_event <= 2'h0;
        // let the synchroniser drain, or a late event edge beats the pop
        repeat (3) @(posedge mclk);
        ahb(1'b0, A_EVT, 32'h0);
        chk(r, 32'h8000_0001);
        ahb(1'b0, A_EVT, 32'h0);
        chk({31'h0, r[31]}, 32'h0);
        $display("test event done");
        close_out();
    end
endmodule : tb_descriptor_dma_condition_sequencer
